// File: rtl/swd_pkg.sv
// swd_pkg: constants and types for the standby and wake domain control
// Overview of operation
// - Host register reads and writes are ignored while main supply good is low.
// - Wake output, external slow clock and wake inputs keep working on trickle supply alone.
// - Infrared half-duplex timeout is disabled whenever main supply good is low.
// - Config register 0xf0 bit 0: 0 external slow clock present, 1 pin grounded.
// - Slow clock config register is reset only by the trickle power-on reset.
// - Bit 0 picks external slow clock or 32 kHz derived from the 14 MHz clock.
// - Derived slow clock needs main power; external clock also runs on trickle power.
// - On trickle power any enabled wake source pulls the active-low wake output down.
// - Designated general-purpose wake inputs stay usable with main supply off.
// - Fan pins drive low after main resets; plain gpio outputs without main power.
// - Alternate infrared transmit pin drives low after every reset; never a wake input.
// - Infrared transmit pins stay low until serial port two is activated.
// - Device-disable pin reverts to gpio keeping direction, inversion and buffer type.
// - Keyboard reset, gate A20 and density-select pins are never wake sources.
// - Both LED pins are driven by trickle-powered blink and steady control.
// - Wake, LED, tachometer and key-wake state is reset only by trickle power-on reset.
package swd_pkg;

    localparam logic [7:0] SWD_SLOW_CFG_ADDR = 8'hf0;
    localparam logic [7:0] SWD_STATUS_ADDR = 8'hf1;
    localparam int SWD_ABSENT_BIT = 0;
    localparam logic SWD_ABSENT_RST = 1'b0;
    localparam logic [7:0] SWD_UNMAPPED_DATA = 8'h00;

    localparam int SWD_OSC14_HZ = 14000000;
    localparam int SWD_SLOW_HZ = 32768;
    localparam int SWD_DIV14 = SWD_OSC14_HZ / SWD_SLOW_HZ;
    localparam int SWD_BLINK_TICKS = SWD_SLOW_HZ / 2;

    localparam int SWD_FIXED_WAKE = 7;
    localparam int SWD_GPIO_WAKE = 8;

    typedef enum logic [1:0] {
        SWD_LED_OFF = 2'b00,
        SWD_LED_BLINK = 2'b01,
        SWD_LED_ON = 2'b10,
        SWD_LED_RSVD = 2'b11
    } swd_led_mode_t;

    typedef struct packed {
        logic out;
        logic oe;
    } swd_pin_t;

    typedef struct packed {
        logic dir_out;
        logic invert;
        logic open_drain;
        logic data;
    } swd_gpio_cfg_t;

    typedef struct packed {
        logic sel;
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } swd_cfg_req_t;

endpackage : swd_pkg

// File: rtl/swd_slow_tick.sv
// swd_slow_tick: slow clock tick source selection and divider
`timescale 1ns/1ns
module swd_slow_tick
    import swd_pkg::*;
#(
    parameter int DIV14 = SWD_DIV14
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic slow_clock_in,
    input wire logic osc14_in,
    input wire logic use_internal,
    input wire logic main_good,
    output logic slow_tick,
    output logic cur_internal
);

    localparam int CW = $clog2(DIV14);

    if (DIV14 < 2) begin : g_chk
        $error("swd_slow_tick: DIV14 must be at least 2");
    end

    typedef struct packed {
        logic in_d;
        logic osc_d;
        logic [CW-1:0] div_cnt;
        logic sel;
        logic tick;
    } swd_tick_state_t;

    swd_tick_state_t st_r;
    swd_tick_state_t st_nxt;
    logic ext_tick;
    logic osc_edge;
    logic int_tick;
    logic new_tick;

    assign ext_tick = slow_clock_in & ~st_r.in_d;
    assign osc_edge = osc14_in & ~st_r.osc_d;
    // derived tick only exists with main power
    assign int_tick = osc_edge & main_good & (st_r.div_cnt == CW'(DIV14 - 1));
    assign new_tick = use_internal ? int_tick : ext_tick;

    always_comb begin
        st_nxt = st_r;
        st_nxt.in_d = slow_clock_in;
        st_nxt.osc_d = osc14_in;
        if (!main_good) begin
            st_nxt.div_cnt = '0;
        end else if (osc_edge) begin
            st_nxt.div_cnt = int_tick ? '0 : st_r.div_cnt + 1'b1;
        end
        // source change takes effect only on a whole tick of the new source
        if (use_internal != st_r.sel) begin
            st_nxt.tick = new_tick;
            if (new_tick) begin
                st_nxt.sel = use_internal;
            end
        end else begin
            st_nxt.tick = st_r.sel ? int_tick : ext_tick;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign slow_tick = st_r.tick;
    assign cur_internal = st_r.sel;

endmodule : swd_slow_tick

// File: rtl/swd_standby_ctrl.sv
// swd_standby_ctrl: standby domain control, wake output and pin defaults
`timescale 1ns/1ns
module swd_standby_ctrl
    import swd_pkg::*;
#(
    parameter int GPIO_WAKE = SWD_GPIO_WAKE,
    parameter int DIV14 = SWD_DIV14,
    parameter int BLINK_TICKS = SWD_BLINK_TICKS
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic main_supply_good,
    input wire logic main_por_n,
    input wire logic hard_reset,
    input wire swd_cfg_req_t cfg_req,
    output logic [7:0] cfg_rdata,
    output logic cfg_rvalid,
    input wire logic slow_clock_in,
    input wire logic osc14_in,
    output logic slow_tick,
    input wire logic ring_indicator_one_n,
    input wire logic ring_indicator_two_n,
    input wire logic keyboard_data_line,
    input wire logic mouse_data_line,
    input wire logic key_wake_event,
    input wire logic [1:0] tach_wake_event,
    input wire logic [GPIO_WAKE-1:0] gpio_wake_in,
    input wire logic [SWD_FIXED_WAKE+GPIO_WAKE-1:0] wake_enable,
    input wire logic [SWD_FIXED_WAKE+GPIO_WAKE-1:0] wake_clear,
    output logic [SWD_FIXED_WAKE+GPIO_WAKE-1:0] wake_status,
    output logic wake_event_out_n_o,
    output logic wake_event_out_n_oe,
    input wire logic ir_hdx_timeout_en,
    output logic ir_hdx_timeout_active,
    input wire logic serial2_activate,
    input wire logic serial2_txd,
    output swd_pin_t ir_transmit_pin_two,
    output swd_pin_t ir_transmit_alt_pin,
    input wire logic [1:0] fan_func_en,
    input wire logic [1:0] fan_pwm,
    input wire logic [1:0] fan_gpio_data,
    output swd_pin_t fan_control_pin_a,
    output swd_pin_t fan_control_pin_b,
    input wire logic dev_disable_func_en,
    input wire swd_gpio_cfg_t dev_disable_gpio,
    input wire logic device_disable_pin_i,
    output swd_pin_t device_disable_pin,
    output logic device_disable_req,
    input wire swd_led_mode_t led_one_mode,
    input wire swd_led_mode_t led_two_mode,
    output swd_pin_t led_pin_one,
    output swd_pin_t led_pin_two
);

    localparam int NW = SWD_FIXED_WAKE + GPIO_WAKE;
    localparam int BW = $clog2(BLINK_TICKS);

    if (GPIO_WAKE < 1) begin : g_chk_gpio
        $error("swd_standby_ctrl: GPIO_WAKE must be at least 1");
    end
    if (BLINK_TICKS < 2) begin : g_chk_blink
        $error("swd_standby_ctrl: BLINK_TICKS must be at least 2");
    end

    typedef struct packed {
        logic pg_meta;
        logic pg_s;
        logic absent;
        logic [7:0] rdata;
        logic rvalid;
        logic ir_release;
        logic [NW-1:0] wake_sts;
        logic [NW-1:0] wake_prev;
        logic [BW-1:0] blink_cnt;
        logic blink_phase;
        logic wake_drive;
        logic hdx_active;
        logic dis_req;
        swd_pin_t ir_two;
        swd_pin_t ir_alt;
        swd_pin_t fan_a;
        swd_pin_t fan_b;
        swd_pin_t dis_pin;
        swd_pin_t led_one;
        swd_pin_t led_two;
    } swd_ctrl_state_t;

    swd_ctrl_state_t st_r;
    swd_ctrl_state_t st_nxt;
    logic pg;
    logic main_rst;
    logic tick;
    logic cur_internal;
    logic [NW-1:0] wake_active;
    logic [NW-1:0] wake_sts_nxt;

    assign pg = st_r.pg_s;
    assign main_rst = ~main_por_n | hard_reset;

    swd_slow_tick #(
        .DIV14(DIV14)
    ) u_tick (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .slow_clock_in(slow_clock_in),
        .osc14_in(osc14_in),
        .use_internal(st_r.absent),
        .main_good(pg),
        .slow_tick(tick),
        .cur_internal(cur_internal)
    );

    // only trickle-kept sources; reset, gate, density, fan and alt ir pins absent
    assign wake_active = {
        gpio_wake_in,
        tach_wake_event,
        key_wake_event,
        ~mouse_data_line,
        ~keyboard_data_line,
        ~ring_indicator_two_n,
        ~ring_indicator_one_n
    };

    for (genvar i = 0; i < NW; i++) begin : g_wake
        // a new edge wins over a clear in the same cycle
        assign wake_sts_nxt[i] = (wake_active[i] & ~st_r.wake_prev[i])
            | (st_r.wake_sts[i] & ~wake_clear[i]);
    end

    function automatic swd_pin_t led_drive(input swd_led_mode_t m, input logic phase);
        swd_pin_t p;
        p.oe = 1'b1;
        unique case (m)
            SWD_LED_OFF: p.out = 1'b0;
            SWD_LED_BLINK: p.out = phase;
            SWD_LED_ON: p.out = 1'b1;
            default: p.out = 1'b0;
        endcase
        return p;
    endfunction : led_drive

    always_comb begin
        st_nxt = st_r;
        // two-stage power-good synchroniser
        st_nxt.pg_meta = main_supply_good;
        st_nxt.pg_s = st_r.pg_meta;

        // register access gated by synchronised power good
        st_nxt.rvalid = 1'b0;
        if (pg && cfg_req.sel && cfg_req.wr && cfg_req.addr == SWD_SLOW_CFG_ADDR) begin
            st_nxt.absent = cfg_req.wdata[SWD_ABSENT_BIT];
        end
        if (pg && cfg_req.sel && cfg_req.rd) begin
            st_nxt.rvalid = 1'b1;
            if (cfg_req.addr == SWD_SLOW_CFG_ADDR) begin
                st_nxt.rdata = {7'h00, st_r.absent};
            end else if (cfg_req.addr == SWD_STATUS_ADDR) begin
                st_nxt.rdata = {5'h00, cur_internal, st_r.wake_drive, pg};
            end else begin
                st_nxt.rdata = SWD_UNMAPPED_DATA;
            end
        end

        // wake capture runs regardless of main power
        st_nxt.wake_prev = wake_active;
        st_nxt.wake_sts = wake_sts_nxt;
        st_nxt.wake_drive = |(st_r.wake_sts & wake_enable);

        st_nxt.hdx_active = ir_hdx_timeout_en & pg;

        // ir transmit pins low until serial port two is activated
        // any main reset drops the release, so both pins come up low
        if (!pg || main_rst) begin
            st_nxt.ir_release = 1'b0;
        end else if (serial2_activate) begin
            st_nxt.ir_release = 1'b1;
        end
        st_nxt.ir_two = '{out: st_r.ir_release & serial2_txd, oe: 1'b1};
        st_nxt.ir_alt = '{out: st_r.ir_release & serial2_txd, oe: 1'b1};

        // fan pins
        if (!pg) begin
            st_nxt.fan_a = '{out: fan_gpio_data[0], oe: 1'b1};
            st_nxt.fan_b = '{out: fan_gpio_data[1], oe: 1'b1};
        end else if (main_rst) begin
            st_nxt.fan_a = '{out: 1'b0, oe: 1'b1};
            st_nxt.fan_b = '{out: 1'b0, oe: 1'b1};
        end else begin
            st_nxt.fan_a = '{out: fan_func_en[0] & fan_pwm[0], oe: 1'b1};
            st_nxt.fan_b = '{out: fan_func_en[1] & fan_pwm[1], oe: 1'b1};
        end

        // device-disable pin falls back to its programmed gpio role
        if (pg && dev_disable_func_en) begin
            st_nxt.dis_pin = '{out: 1'b0, oe: 1'b0};
            st_nxt.dis_req = device_disable_pin_i;
        end else begin
            st_nxt.dis_req = 1'b0;
            st_nxt.dis_pin.out = dev_disable_gpio.data ^ dev_disable_gpio.invert;
            st_nxt.dis_pin.oe = dev_disable_gpio.dir_out
                & (~dev_disable_gpio.open_drain | ~st_nxt.dis_pin.out);
        end

        // blink timing counted on slow ticks, trickle domain
        if (tick) begin
            if (st_r.blink_cnt == BW'(BLINK_TICKS - 1)) begin
                st_nxt.blink_cnt = '0;
                st_nxt.blink_phase = ~st_r.blink_phase;
            end else begin
                st_nxt.blink_cnt = st_r.blink_cnt + 1'b1;
            end
        end
        st_nxt.led_one = led_drive(led_one_mode, st_r.blink_phase);
        st_nxt.led_two = led_drive(led_two_mode, st_r.blink_phase);
    end

    // trickle power-on reset only; main resets just drop the ir release and drive the fan pins low
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_r <= '0;
            st_r.absent <= SWD_ABSENT_RST;
            st_r.ir_two <= '{out: 1'b0, oe: 1'b1};
            st_r.ir_alt <= '{out: 1'b0, oe: 1'b1};
            st_r.fan_a <= '{out: 1'b0, oe: 1'b1};
            st_r.fan_b <= '{out: 1'b0, oe: 1'b1};
            st_r.led_one <= '{out: 1'b0, oe: 1'b1};
            st_r.led_two <= '{out: 1'b0, oe: 1'b1};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign cfg_rdata = st_r.rdata;
    assign cfg_rvalid = st_r.rvalid;
    assign slow_tick = tick;
    assign wake_status = st_r.wake_sts;
    assign wake_event_out_n_o = 1'b0;
    assign wake_event_out_n_oe = st_r.wake_drive;
    assign ir_hdx_timeout_active = st_r.hdx_active;
    assign ir_transmit_pin_two = st_r.ir_two;
    assign ir_transmit_alt_pin = st_r.ir_alt;
    assign fan_control_pin_a = st_r.fan_a;
    assign fan_control_pin_b = st_r.fan_b;
    assign device_disable_pin = st_r.dis_pin;
    assign device_disable_req = st_r.dis_req;
    assign led_pin_one = st_r.led_one;
    assign led_pin_two = st_r.led_two;

endmodule : swd_standby_ctrl

// File: test/swd_chipset_model.sv
// chipset side of the wake line, with its pull-up
`timescale 1ns/1ns
module swd_chipset_model (
    input wire logic wake_event_out_n_o,
    input wire logic wake_event_out_n_oe,
    output logic wake_line
);
    // released line floats up to the pull-up level
    assign wake_line = wake_event_out_n_oe ? wake_event_out_n_o : 1'b1;
endmodule : swd_chipset_model

// File: test/swd_standby_ctrl_chk.sv
// port assertions for swd_standby_ctrl
`timescale 1ns/1ns
module swd_standby_ctrl_chk
    import swd_pkg::*;
#(
    parameter int GPIO_WAKE = SWD_GPIO_WAKE
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic main_supply_good,
    input wire swd_cfg_req_t cfg_req,
    input wire logic [7:0] cfg_rdata,
    input wire logic cfg_rvalid,
    input wire logic ring_indicator_one_n,
    input wire logic [SWD_FIXED_WAKE+GPIO_WAKE-1:0] wake_enable,
    input wire logic [SWD_FIXED_WAKE+GPIO_WAKE-1:0] wake_status,
    input wire logic wake_event_out_n_o,
    input wire logic wake_event_out_n_oe,
    input wire logic ir_hdx_timeout_active,
    input wire logic [1:0] fan_gpio_data,
    input wire swd_pin_t fan_control_pin_a,
    input wire swd_pin_t ir_transmit_pin_two,
    input wire swd_pin_t led_pin_one,
    input wire swd_pin_t led_pin_two
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    chk_refused_read: assert property ($past(!main_supply_good, 2) && $past(!main_supply_good)
        && !main_supply_good && cfg_req.sel && cfg_req.rd |=> !cfg_rvalid)
        else $error("read answered while main supply low");
    chk_read_answer: assert property ($past(rstn, 3) && main_supply_good && cfg_req.sel
        && cfg_req.rd && $past(main_supply_good) && $past(main_supply_good, 2)
        |-> ##[1:2] cfg_rvalid) else $error("read not answered");
    chk_status_read: assert property (cfg_rvalid && $past(cfg_req.addr) == SWD_STATUS_ADDR
        |-> cfg_rdata[7:3] == 5'h00 && cfg_rdata[0]) else $error("status read wrong");
    chk_cfg_bits: assert property (cfg_rvalid && $past(cfg_req.addr) == SWD_SLOW_CFG_ADDR
        |-> cfg_rdata[7:1] == 7'h00) else $error("config upper bits set");
    chk_wake_drive: assert property (wake_event_out_n_oe
        == $past(|(wake_status & wake_enable))) else $error("wake drive wrong");
    chk_wake_low: assert property (wake_event_out_n_o == 1'b0)
        else $error("wake line driven high");
    chk_ring_sets: assert property ($fell(ring_indicator_one_n) |=> wake_status[0])
        else $error("ring edge not latched");
    chk_hdx_off: assert property (!main_supply_good |-> ##3 !ir_hdx_timeout_active)
        else $error("half duplex timeout live without main supply");
    chk_fan_gpio: assert property ((!main_supply_good)[*4] |-> fan_control_pin_a.oe
        && fan_control_pin_a.out == $past(fan_gpio_data[0])) else $error("fan pin not gpio");
    chk_ir_held: assert property ((!main_supply_good)[*4] |=> ir_transmit_pin_two.oe
        && !ir_transmit_pin_two.out) else $error("ir pin not held low");
    chk_led_driven: assert property (led_pin_one.oe && led_pin_two.oe)
        else $error("led pin released");
endmodule : swd_standby_ctrl_chk

bind swd_standby_ctrl swd_standby_ctrl_chk #(.GPIO_WAKE(GPIO_WAKE)) u_chk (
    .sys_clk(sys_clk), .rstn(rstn), .main_supply_good(main_supply_good),
    .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
    .ring_indicator_one_n(ring_indicator_one_n), .wake_enable(wake_enable),
    .wake_status(wake_status), .wake_event_out_n_o(wake_event_out_n_o),
    .wake_event_out_n_oe(wake_event_out_n_oe), .ir_hdx_timeout_active(ir_hdx_timeout_active),
    .fan_gpio_data(fan_gpio_data), .fan_control_pin_a(fan_control_pin_a),
    .ir_transmit_pin_two(ir_transmit_pin_two), .led_pin_one(led_pin_one),
    .led_pin_two(led_pin_two));

// File: test/tb.sv
// self-checking bench for swd_standby_ctrl
`timescale 1ns/1ns
module tb;
    import swd_pkg::*;
    localparam int NW = SWD_FIXED_WAKE + SWD_GPIO_WAKE;
    logic sys_clk = 1'b0, rstn = 1'b0, good = 1'b1, por_n = 1'b1, hrst = 1'b0;
    swd_cfg_req_t req = '0;
    logic [7:0] rdata, d, a;
    logic rvalid, tick, wo, woe, wline, hdx, ddr, g, prev;
    logic slow_in = 1'b0, osc = 1'b0, run14 = 1'b0, run32 = 1'b0, hdx_en = 1'b0;
    logic s2_act = 1'b0, s2_txd = 1'b1, dd_en = 1'b1, ddi = 1'b1;
    logic [NW-1:0] act = '0, wen = '0, wclr = '0, wst;
    logic [1:0] fan_en = 2'b11, pwm = 2'b11, fgd = '0;
    logic [2:0] div = '0;
    swd_pin_t ir2, ir_alt, fan_a, fan_b, dd_pin, led1, led2;
    swd_gpio_cfg_t dd_cfg = '0;
    swd_led_mode_t m1 = SWD_LED_OFF, m2 = SWD_LED_OFF;
    int n_mismatch = 0, checked = 0, seed = 58761, n_tick = 0, i, tog;

    swd_standby_ctrl #(.DIV14(4), .BLINK_TICKS(4)) u_swd_standby_ctrl (
        .sys_clk(sys_clk), .rstn(rstn), .main_supply_good(good), .main_por_n(por_n),
        .hard_reset(hrst), .cfg_req(req), .cfg_rdata(rdata), .cfg_rvalid(rvalid),
        .slow_clock_in(slow_in), .osc14_in(osc), .slow_tick(tick),
        .ring_indicator_one_n(~act[0]), .ring_indicator_two_n(~act[1]),
        .keyboard_data_line(~act[2]), .mouse_data_line(~act[3]), .key_wake_event(act[4]),
        .tach_wake_event(act[6:5]), .gpio_wake_in(act[NW-1:7]), .wake_enable(wen),
        .wake_clear(wclr), .wake_status(wst), .wake_event_out_n_o(wo),
        .wake_event_out_n_oe(woe), .ir_hdx_timeout_en(hdx_en), .ir_hdx_timeout_active(hdx),
        .serial2_activate(s2_act), .serial2_txd(s2_txd), .ir_transmit_pin_two(ir2),
        .ir_transmit_alt_pin(ir_alt), .fan_func_en(fan_en), .fan_pwm(pwm),
        .fan_gpio_data(fgd), .fan_control_pin_a(fan_a), .fan_control_pin_b(fan_b),
        .dev_disable_func_en(dd_en), .dev_disable_gpio(dd_cfg), .device_disable_pin_i(ddi),
        .device_disable_pin(dd_pin), .device_disable_req(ddr), .led_one_mode(m1),
        .led_two_mode(m2), .led_pin_one(led1), .led_pin_two(led2));

    swd_chipset_model u_swd_chipset_model (
        .wake_event_out_n_o(wo), .wake_event_out_n_oe(woe), .wake_line(wline));

    always #4 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        #1;
        if (run14) begin
            osc = ~osc;
        end
        div = div + 3'h1;
        if (run32 && div == 3'h0) begin
            slow_in = ~slow_in;
        end
        if (tick) begin
            n_tick++;
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : step

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic give_verdict;
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict

    // one register access, then a bounded wait for the read answer
    task automatic acc(input logic w, input logic [7:0] ad, input logic [7:0] wd);
        req = '{sel: 1'b1, rd: ~w, wr: w, addr: ad, wdata: wd};
        step(1);
        req = '0;
        g = 1'b0;
        d = 8'h00;
        for (int k = 0; k < 3 && !g; k++) begin
            if (rvalid === 1'b1) begin
                g = 1'b1;
                d = rdata;
            end else begin
                step(1);
            end
        end
    endtask : acc

    task automatic rd_chk(input logic [7:0] ad, input logic [8:0] exp);
        acc(1'b0, ad, 8'h00);
        chk("read", {g, d}, exp);
    endtask : rd_chk

    task automatic count_ticks(input int lo, input int hi);
        n_tick = 0;
        step(64);
        chk("ticks", n_tick >= lo && n_tick <= hi, 1'b1);
    endtask : count_ticks

    task automatic wake_try(input int b);
        act[b] = 1'b1;
        step(3);
        chk("wake set", {wst[b], wline}, 2'b10);
        wclr[b] = 1'b1;
        step(1);
        wclr[b] = 1'b0;
        step(3);
        chk("wake held", {wst[b], wline}, 2'b01);
        act[b] = 1'b0;
        step(1);
    endtask : wake_try

    task automatic set_good(input logic v);
        good = v;
        step(5);
    endtask : set_good

    initial begin
        step(6);
        rstn = 1'b1;
        step(3);
        chk("ir pins", {ir_alt, ir2}, 4'h5);
        rd_chk(8'hf0, 9'h100);
        acc(1'b1, 8'hf0, 8'h01);
        rd_chk(8'hf0, 9'h101);
        acc(1'b0, 8'hf1, 8'h00);
        chk("status", {g, d[7:3], d[0]}, 7'h41);
        for (i = 0; i < 8; i++) begin
            a = $random(seed);
            acc(1'b1, a | 8'h02, $random(seed));
            rd_chk(a | 8'h02, 9'h100);
        end
        run14 = 1'b1;
        count_ticks(7, 9);
        por_n = 1'b0;
        hrst = 1'b1;
        step(3);
        chk("fan reset", {fan_a, fan_b}, 4'h5);
        por_n = 1'b1;
        hrst = 1'b0;
        rd_chk(8'hf0, 9'h101);
        chk("fan run", {fan_a, fan_b}, 4'hf);
        chk("dd func", {dd_pin, ddr}, 3'h1);
        hdx_en = 1'b1;
        wen = 15'h7f9f;
        fgd = 2'b10;
        dd_cfg = '{dir_out: 1'b1, invert: 1'b1, open_drain: 1'b0, data: 1'b0};
        set_good(1'b0);
        count_ticks(0, 0);
        chk("hdx", hdx, 1'b0);
        chk("fan gpio", {fan_a, fan_b}, 4'h7);
        chk("dd pin", {dd_pin, ddr}, 3'h6);
        acc(1'b1, 8'hf0, 8'h00);
        rd_chk(8'hf0, 9'h000);
        set_good(1'b1);
        rd_chk(8'hf0, 9'h101);
        chk("hdx", hdx, 1'b1);
        acc(1'b1, 8'hf0, 8'h00);
        run32 = 1'b1;
        step(32);
        count_ticks(3, 5);
        m1 = SWD_LED_BLINK;
        set_good(1'b0);
        count_ticks(3, 5);
        tog = 0;
        for (i = 0; i < 160; i++) begin
            prev = led1.out;
            step(1);
            tog += (led1.out !== prev);
        end
        chk("blink", tog >= 2, 1'b1);
        wake_try(0);
        wake_try(NW - 1);
        set_good(1'b1);
        wen = '1;
        for (i = 0; i < NW; i++) begin
            wake_try(i);
        end
        s2_act = 1'b1;
        for (i = 0; i < 6; i++) begin
            s2_txd = $random(seed);
            step(3);
            chk("ir tx", {ir_alt.out, ir2.out}, {2{s2_txd}});
        end
        set_good(1'b0);
        chk("ir off", {ir_alt, ir2}, 4'h5);
        m1 = SWD_LED_ON;
        m2 = SWD_LED_RSVD;
        step(3);
        chk("led", {led1.out, led2.out}, 2'b10);
        give_verdict();
    end

    initial begin
        #200000;
        n_mismatch++;
        give_verdict();
    end
endmodule : tb
